/* wdt_defines.svh */
/*
 * timing constants for the reset supervisor.
 * assumes a 40 MHz system clock; included by its bare name.
 */
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

// clock period in nanoseconds (25 ns)
`define WDT_CLK_PERIOD_NS   25
// nominal least watchdog period in nanoseconds (6.25 ms); kept in ns so the
// arithmetic stays inside 32 bits
`define WDT_PERIOD_NS       6250000
// period in cycles: least time, rounded up
`define WDT_PERIOD_CYC      ((`WDT_PERIOD_NS + `WDT_CLK_PERIOD_NS - 1) / `WDT_CLK_PERIOD_NS)
// width of the period counter
`define WDT_CNT_W           20
// reset value of the output: low (reset asserted)
`define WDT_RST_OUT_INIT    1'b0

`endif

/* wdt_pkg.sv */
/*
 * types shared by the reset supervisor modules.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package wdt_pkg;
    // supervisor phases
    typedef enum logic [1:0] {
        ST_POR,
        ST_RUN,
        ST_PULSE_LOW,
        ST_PULSE_HIGH
    } sup_state_t;
endpackage : wdt_pkg

/* kick_if.sv */
/*
 * carries the kick detection between the edge module and the supervisor.
 * assumes both ends share clk_i.
 */
`timescale 1ns/1ps
interface kick_if;
    logic kick_fall;
    modport det (output kick_fall);
    modport sup (input  kick_fall);
endinterface : kick_if

/* kick_edge_det.sv */
/*
 * two-stage synchroniser and falling-edge detector for the kick pin.
 * assumes the pin is asynchronous to clk_i.
 */
`timescale 1ns/1ps
module kick_edge_det (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    // kick pin
    input  wire logic watchdog_kick_in_i,
    // detection out
    kick_if.det       kb
);
    logic sync1_r;
    logic sync2_r;
    logic prev_r;
    logic fall_r;

    // synchroniser; first stage read only by the second
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
        end else begin
            sync1_r <= watchdog_kick_in_i;
            sync2_r <= sync1_r;
        end
    end

    // only high-to-low counts, levels and rises do nothing
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            prev_r <= 1'b1;
            fall_r <= 1'b0;
        end else begin
            prev_r <= sync2_r;
            fall_r <= prev_r & ~sync2_r;
        end
    end

    assign kb.kick_fall = fall_r;

    property p_rise_no_pulse;
        @(posedge clk_i) disable iff (sys_rst_i)
        (~$past(sync2_r) & sync2_r) |=> !fall_r;
    endproperty
    a_rise_no_pulse: assert property (p_rise_no_pulse) else $error("kick pulse on rising edge");
endmodule : kick_edge_det

/* watchdog_reset_supervisor.sv */
/*
 * watchdog and power-on reset supervisor driving an active-low reset.
 * assumes rail_good_i comes from an external hysteretic comparator and
 * the kick pin from a processor; both are asynchronous to clk_i.
 */
`timescale 1ns/1ps
`include "wdt_defines.svh"

module watchdog_reset_supervisor #(
    parameter int unsigned CNT_W      = `WDT_CNT_W,
    parameter int unsigned PERIOD_CYC = `WDT_PERIOD_CYC
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    // supervised inputs
    input  wire logic watchdog_kick_in_i,
    input  wire logic rail_good_i,
    // reset output
    output logic      reset_n_o,
    // current phase, for observation
    output wdt_pkg::sup_state_t state_o
);
    import wdt_pkg::*;

    localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD_CYC - 1);

    kick_if kb ();

    sup_state_t      state_r;
    logic [CNT_W-1:0] cnt_r;
    logic            rg_s1_r;
    logic            rg_s2_r;
    logic            reset_n_r;
    logic            expire;
    logic            kick;

    // edge detection lives in its own module
    kick_edge_det u_kick (
        .clk_i              (clk_i),
        .sys_rst_i          (sys_rst_i),
        .watchdog_kick_in_i (watchdog_kick_in_i),
        .kb                 (kb)
    );

    assign kick   = kb.kick_fall;
    assign expire = (cnt_r == LAST);

    // rail-good synchroniser; thresholds and hysteresis are analog
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rg_s1_r <= 1'b0;
            rg_s2_r <= 1'b0;
        end else begin
            rg_s1_r <= rail_good_i;
            rg_s2_r <= rg_s1_r;
        end
    end

    // supervisor phases; low rail overrides everything
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_r <= ST_POR;
        end else if (!rg_s2_r) begin
            state_r <= ST_POR;
        end else begin
            unique case (state_r)
                ST_POR: begin
                    if (expire) state_r <= ST_RUN;
                end
                ST_RUN: begin
                    if (!kick && expire) state_r <= ST_PULSE_LOW;
                end
                ST_PULSE_LOW: begin
                    // kicks during the low phase are not looked at
                    if (expire) state_r <= ST_PULSE_HIGH;
                end
                ST_PULSE_HIGH: begin
                    if (kick) state_r <= ST_RUN;
                    else if (expire) state_r <= ST_PULSE_LOW;
                end
            endcase
        end
    end

    // period counter; a kick in run or in the high phase restarts it, phase changes wrap it
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !rg_s2_r) begin
            cnt_r <= '0;
        end else if ((state_r == ST_RUN || state_r == ST_PULSE_HIGH) && kick) begin
            cnt_r <= '0;
        end else if (expire) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + CNT_W'(1);
        end
    end

    // registered output avoids glitches on the reset line
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            reset_n_r <= `WDT_RST_OUT_INIT;
        end else if (!rg_s2_r) begin
            reset_n_r <= 1'b0;
        end else begin
            unique case (state_r)
                ST_POR:        reset_n_r <= expire;
                ST_RUN:        reset_n_r <= !( !kick && expire);
                ST_PULSE_LOW:  reset_n_r <= expire;
                ST_PULSE_HIGH: reset_n_r <= kick || !expire;
            endcase
        end
    end

    assign reset_n_o = reset_n_r;
    assign state_o   = state_r;

    // rail low forces reset within the synchroniser delay
    property p_rail_low;
        @(posedge clk_i) disable iff (sys_rst_i)
        !rail_good_i [*3] |=> !reset_n_o;
    endproperty
    a_rail_low: assert property (p_rail_low) else $error("reset high with rail low");

    // reset stays low for as long as the power-on hold lasts
    property p_por_low;
        @(posedge clk_i) disable iff (sys_rst_i)
        (state_r == ST_POR) |-> !reset_n_o;
    endproperty
    a_por_low: assert property (p_por_low) else $error("reset released during hold");

    // hold lasts exactly the period once rail stays good
    property p_por_len;
        @(posedge clk_i) disable iff (sys_rst_i)
        (state_r == ST_POR && cnt_r == LAST && rg_s2_r) |=> (state_r == ST_RUN) && reset_n_o;
    endproperty
    a_por_len: assert property (p_por_len) else $error("hold period wrong");

    // timeout without kick starts a low phase
    property p_timeout;
        @(posedge clk_i) disable iff (sys_rst_i)
        (state_r == ST_RUN && expire && !kick && rg_s2_r) |=> state_r == ST_PULSE_LOW && !reset_n_o;
    endproperty
    a_timeout: assert property (p_timeout) else $error("missed timeout");

    sequence s_low_end;
        state_r == ST_PULSE_LOW && expire && rg_s2_r;
    endsequence
    // low phase flips to high after one period
    property p_half;
        @(posedge clk_i) disable iff (sys_rst_i)
        s_low_end |=> state_r == ST_PULSE_HIGH && reset_n_o;
    endproperty
    a_half: assert property (p_half) else $error("low phase length wrong");

    // high phase without kick returns low after one period
    property p_high_end;
        @(posedge clk_i) disable iff (sys_rst_i)
        (state_r == ST_PULSE_HIGH && expire && !kick && rg_s2_r) |=> !reset_n_o;
    endproperty
    a_high_end: assert property (p_high_end) else $error("square wave broken");

    // kick in high phase ends the train
    property p_kick_end;
        @(posedge clk_i) disable iff (sys_rst_i)
        (state_r == ST_PULSE_HIGH && kick && rg_s2_r) |=> state_r == ST_RUN && cnt_r == '0;
    endproperty
    a_kick_end: assert property (p_kick_end) else $error("kick did not end train");

    // kick in run restarts count
    property p_kick_clr;
        @(posedge clk_i) disable iff (sys_rst_i)
        (state_r == ST_RUN && kick && rg_s2_r) |=> cnt_r == '0 && reset_n_o;
    endproperty
    a_kick_clr: assert property (p_kick_clr) else $error("kick did not restart count");

    // counter never passes the period
    property p_cnt_max;
        @(posedge clk_i) disable iff (sys_rst_i)
        cnt_r <= LAST;
    endproperty
    a_cnt_max: assert property (p_cnt_max) else $error("counter overran");

    // a kick during the low phase changes nothing
    property p_low_kick;
        @(posedge clk_i) disable iff (sys_rst_i)
        (state_r == ST_PULSE_LOW && kick && !expire && rg_s2_r) |=>
            state_r == ST_PULSE_LOW && !reset_n_o;
    endproperty
    a_low_kick: assert property (p_low_kick) else $error("low phase took a kick");

    // a serviced watchdog keeps reset released until the count runs out
    property p_run_hold;
        @(posedge clk_i) disable iff (sys_rst_i)
        (state_r == ST_RUN && !expire && rg_s2_r) |=> state_r == ST_RUN && reset_n_o;
    endproperty
    a_run_hold: assert property (p_run_hold) else $error("reset while serviced");

    // high phase holds until a kick or the end of the period
    property p_high_hold;
        @(posedge clk_i) disable iff (sys_rst_i)
        (state_r == ST_PULSE_HIGH && !kick && !expire && rg_s2_r) |=>
            state_r == ST_PULSE_HIGH && reset_n_o;
    endproperty
    a_high_hold: assert property (p_high_hold) else $error("high phase cut short");

    // power-on hold waits out the full count
    property p_por_wait;
        @(posedge clk_i) disable iff (sys_rst_i)
        (state_r == ST_POR && !expire && rg_s2_r) |=> state_r == ST_POR && !reset_n_o;
    endproperty
    a_por_wait: assert property (p_por_wait) else $error("hold ended early");

    // a low rail must not leave a stale count behind for the next hold
    property p_rail_clear;
        @(posedge clk_i) disable iff (sys_rst_i)
        !rg_s2_r |=> state_r == ST_POR && cnt_r == '0;
    endproperty
    a_rail_clear: assert property (p_rail_clear) else $error("count kept through low rail");
endmodule : watchdog_reset_supervisor

/* kick_host.sv */
/*
 * processor model that services the supervisor kick pin.
 * assumes a shared clk_i; the pin idles high as if pulled up.
 */
`timescale 1ns/1ps
module kick_host #(
    parameter int unsigned GAP = 10
) (
    // clock
    input  wire logic clk_i,
    // periodic service enable, single kick request
    input  wire logic run_i,
    input  wire logic once_i,
    // kick pin
    output logic      kick_o
);
    // one low pulse, well wider than the two-flop synchroniser needs
    task automatic kick();
        #2 kick_o = 1'b0;
        repeat (2) @(posedge clk_i);
        #2 kick_o = 1'b1;
    endtask : kick

    // one process owns the pin; periodic kicks stay well inside the least
    // period, leaving margin for tolerance
    initial begin
        kick_o = 1'b1;
        forever begin
            @(posedge clk_i);
            if (run_i) begin
                repeat (GAP - 3) @(posedge clk_i);
                @(posedge clk_i);
                kick();
            end else if (once_i) begin
                kick();
            end
        end
    end
endmodule : kick_host

/* testbench.sv */
/*
 * self-checking bench for the watchdog reset supervisor.
 * assumes a shortened period of 20 cycles and the kick_host model.
 */
`timescale 1ns/1ps
module testbench;
    import wdt_pkg::*;
    localparam int unsigned P = 20;

    logic       clk_i       = 1'b0;
    logic       sys_rst_i   = 1'b1;
    logic       rail_good_i = 1'b0;
    logic       run         = 1'b0;
    logic       once        = 1'b0;
    wire logic  kick;
    logic       reset_n_o;
    sup_state_t state_o;
    int         num_errors  = 0;
    int         check_count = 0;
    int         n;

    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;

    kick_host #(.GAP(10)) host (
        .clk_i  (clk_i),
        .run_i  (run),
        .once_i (once),
        .kick_o (kick)
    );

    watchdog_reset_supervisor #(.PERIOD_CYC(P)) dut (
        .clk_i              (clk_i),
        .sys_rst_i          (sys_rst_i),
        .watchdog_kick_in_i (kick),
        .rail_good_i        (rail_good_i),
        .reset_n_o          (reset_n_o),
        .state_o            (state_o)
    );

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        if (num_errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test

    // counts cycles until reset_n_o shows v; a hang ends the run
    task automatic wait_rst(input logic v, input int max, output int cyc);
        cyc = 0;
        while (reset_n_o !== v && cyc < max) begin
            @(posedge clk_i);
            #1 cyc++;
        end
        if (reset_n_o !== v) begin
            num_errors++;
            finish_test();
        end
    endtask : wait_rst

    // asks the host for one kick outside its periodic run
    task automatic kick_once();
        #1 once = 1'b1;
        @(posedge clk_i);
        #2 once = 1'b0;
    endtask : kick_once

    // power-up: low while rail is bad, then held one period
    task automatic t_power_on();
        repeat (10) @(posedge clk_i);
        #1 check("rst rail low", reset_n_o, 1'b0);
        #1 rail_good_i = 1'b1;
        wait_rst(1'b1, 3 * P, n);
        check("por hold min", n >= P, 1'b1);
        check("por hold max", n <= P + 6, 1'b1);
        check("run state", state_o, ST_RUN);
    endtask : t_power_on

    // regular kicks keep the output released
    task automatic t_kicked();
        run = 1'b1;
        n = 0;
        repeat (6 * P) begin
            @(posedge clk_i);
            #1 if (reset_n_o !== 1'b1) n++;
        end
        check("kicked lows", n, 0);
    endtask : t_kicked

    // missed kick: square wave, low-phase kick ignored, high-phase kick ends it
    task automatic t_train();
        run = 1'b0;
        wait_rst(1'b0, P + 10, n);
        check("low state", state_o, ST_PULSE_LOW);
        wait_rst(1'b1, 2 * P, n);
        check("low phase", n, P);
        wait_rst(1'b0, 2 * P, n);
        check("high phase", n, P);
        kick_once();
        wait_rst(1'b1, 2 * P, n);
        check("low kick ignored", n, P - 1);
        kick_once();
        run = 1'b1;
        repeat (4 * P) @(posedge clk_i);
        #1 check("train ended", reset_n_o, 1'b1);
        check("back to run", state_o, ST_RUN);
    endtask : t_train

    // brown-out reuses the power-on path
    task automatic t_brownout();
        #1 rail_good_i = 1'b0;
        wait_rst(1'b0, 6, n);
        check("brownout state", state_o, ST_POR);
        #1 rail_good_i = 1'b1;
        wait_rst(1'b1, 3 * P, n);
        check("rehold", n >= P, 1'b1);
    endtask : t_brownout

    initial begin
        repeat (16) @(posedge clk_i);
        #2 sys_rst_i = 1'b0;
        t_power_on();
        t_kicked();
        t_train();
        t_brownout();
        finish_test();
    end
endmodule : testbench
